// *** include/tws_cfg.svh ***
// Purpose: constants for the two-wire register slave
// Assumes: included by bare name
// Notes: offsets, bus codes and counts of the slave live here; state codes are in tws_pkg
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
// ---------------------------------------------------------------
// bus address and direction
// ---------------------------------------------------------------
`define TWS_ADDR_HI 5'h12
`define TWS_DIR_WRITE 1'h0
`define TWS_DIR_READ 1'h1
// ---------------------------------------------------------------
// framing
// ---------------------------------------------------------------
`define TWS_BIT_LAST 3'h7
`define TWS_BIT_ZERO 3'h0
`define TWS_PTR_RST 8'h00
`define TWS_BYTE_RST 8'h00
// ---------------------------------------------------------------
// rates: system clock 100 MHz, bus up to 400 kHz
// ---------------------------------------------------------------
`define TWS_MCLK_KHZ 100000
`define TWS_FAST_KHZ 400
`define TWS_STD_KHZ 100
`endif

// *** include/tws_pkg.sv ***
// Purpose: types for the two-wire register slave
// Assumes: tws_cfg.svh holds the numbers
// Notes: one-hot state codes written out
package tws_pkg;
    // ---------------------------------------------------------------
    // controller states
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RXB = 7'h08,
        ST_RACK = 7'h10,
        ST_TXB = 7'h20,
        ST_TACK = 7'h40
    } tws_state_t;
    // register file request towards the device core
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
        logic wr;
    } tws_req_t;
endpackage

// *** verif/two_wire_register_slave_tb_top.sv ***
// Purpose: self-checking bench for the two-wire register slave
// Assumes: register storage modelled here, read data one cycle late
// Notes: master delays are whole mclk periods, so its pins change on mclk rises
`timescale 1ns/1ns
module two_wire_register_slave_tb_top;
    logic mclk, rstn, scl, sda_pull, sda_out, sda_oe_n, reg_wr, ak;
    logic [1:0] addr_sel;
    logic [7:0] rd_data, ptr, b;
    tws_pkg::tws_req_t reg_req, last_req;
    wire logic sda_line;
    logic [7:0] regs [256];
    int n_errors, n_compared, n_writes, w0;
    // ---------------------------------------------------------------
    // wire, device, master and register store
    // ---------------------------------------------------------------
    // open drain: either party pulls low, otherwise pulled up
    assign sda_line = ~(sda_pull | (~sda_oe_n & ~sda_out));
    tws_slave tws_slave_inst (.mclk(mclk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_sel(addr_sel), .reg_req(reg_req), .reg_wr(reg_wr),
        .rd_data(rd_data), .ptr(ptr));
    tws_master tws_master_inst (.scl(scl), .sda_pull(sda_pull),
        .sda_line(sda_line));
    // store writes and serve reads at the retained pointer
    always @(posedge mclk) begin
        if (reg_wr === 1'h1) begin
            regs[reg_req.ptr] <= reg_req.data;
            n_writes <= n_writes + 1;
            last_req <= reg_req;
        end
        rd_data <= regs[ptr];
    end
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", what, e, g);
            n_errors++;
        end
    endtask
    task automatic settle();
        repeat (20) @(posedge mclk);
    endtask
    task automatic wrap_up();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // full write of one byte, then pointer and store checked
    task automatic write_example();
        @(posedge mclk) addr_sel <= 2'h3;
        w0 = n_writes;
        tws_master_inst.bus_start();
        tws_master_inst.put_byte(8'h96, ak);
        chk("addr ack", 8'h01, {7'h00, ak});
        tws_master_inst.put_byte(8'h6d, ak);
        chk("ptr ack", 8'h01, {7'h00, ak});
        tws_master_inst.put_byte(8'h92, ak);
        chk("data ack", 8'h01, {7'h00, ak});
        tws_master_inst.bus_stop();
        settle();
        chk("writes", 8'h01, 8'(n_writes - w0));
        chk("wr ptr", 8'h6d, last_req.ptr);
        chk("wr data", 8'h92, last_req.data);
        chk("wr flag", 8'h01, {7'h00, last_req.wr});
        chk("ptr", 8'h6d, ptr);
    endtask
    // pointer write, repeated start, two reads with no new pointer
    task automatic read_twice();
        tws_master_inst.bus_start();
        tws_master_inst.put_byte(8'h96, ak);
        tws_master_inst.put_byte(8'h6d, ak);
        for (int k = 0; k < 2; k++) begin
            tws_master_inst.bus_start();
            tws_master_inst.put_byte(8'h97, ak);
            chk("rd ack", 8'h01, {7'h00, ak});
            tws_master_inst.get_byte(1'h0, b);
            chk("rd byte", 8'h92, b);
        end
        tws_master_inst.bus_stop();
        settle();
        chk("ptr after nack", 8'h6d, ptr);
    endtask
    // every select value: foreign address ignored, own one served
    task automatic select_loop();
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk) addr_sel <= 2'(s);
            settle();
            w0 = n_writes;
            tws_master_inst.bus_start();
            tws_master_inst.put_byte({5'h12, 2'(s) ^ 2'h1, 1'h0}, ak);
            chk("foreign ack", 8'h00, {7'h00, ak});
            tws_master_inst.put_byte(8'h10, ak);
            chk("ignored ack", 8'h00, {7'h00, ak});
            tws_master_inst.bus_stop();
            settle();
            chk("no write", 8'h00, 8'(n_writes - w0));
            tws_master_inst.bus_start();
            tws_master_inst.put_byte({5'h12, 2'(s), 1'h0}, ak);
            chk("own ack", 8'h01, {7'h00, ak});
            tws_master_inst.put_byte(8'h20 + 8'(s), ak);
            tws_master_inst.put_byte(8'hc0 + 8'(s), ak);
            tws_master_inst.bus_start();
            tws_master_inst.put_byte({5'h12, 2'(s), 1'h1}, ak);
            tws_master_inst.get_byte(1'h0, b);
            chk("sel read", 8'hc0 + 8'(s), b);
            tws_master_inst.bus_stop();
        end
    endtask
    // partial byte cut by a stop stores nothing; pointer-only write
    task automatic abort_then_ptr();
        w0 = n_writes;
        tws_master_inst.bus_start();
        tws_master_inst.put_byte(8'h97 ^ 8'h01, ak);
        tws_master_inst.put_byte(8'h21, ak);
        for (int i = 0; i < 4; i++) tws_master_inst.bit_cycle(1'h0, ak);
        tws_master_inst.bus_stop();
        settle();
        chk("cut byte", 8'h00, 8'(n_writes - w0));
        chk("kept", 8'hc1, regs[8'h21]);
        tws_master_inst.bus_start();
        tws_master_inst.put_byte(8'h96, ak);
        tws_master_inst.put_byte(8'h6d, ak);
        tws_master_inst.bus_stop();
        tws_master_inst.bus_start();
        tws_master_inst.put_byte(8'h97, ak);
        tws_master_inst.get_byte(1'h0, b);
        tws_master_inst.bus_stop();
        chk("ptr only read", 8'h92, b);
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        rstn = 1'h0;
        addr_sel = 2'h0;
        rd_data = 8'h00;
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(posedge mclk);
        chk("oe_n in reset", 8'h01, {7'h00, sda_oe_n});
        chk("ptr in reset", 8'h00, ptr);
        rstn <= 1'h1;
        repeat (10) @(posedge mclk);
        write_example();
        read_twice();
        select_loop();
        abort_then_ptr();
        wrap_up();
    end
    // whole run needs well under this span
    initial begin
        #600000;
        n_errors++;
        wrap_up();
    end
endmodule

// *** verif/tws_master.sv ***
// Purpose: behavioural two-wire bus master driving the slave's pins
// Assumes: 160 ns serial period, line pulled up when nobody pulls it low
// Notes: data moves an eighth of a period (20 ns) after the clock falls
`timescale 1ns/1ns
module tws_master (
    // serial pins as seen by the master
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    localparam int HALF = 80;
    // bus idles with the clock high and the data line released
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end
    // start, or repeated start when the clock is low
    task automatic bus_start();
        if (scl === 1'h0) begin
            sda_pull = 1'h0;
            #HALF; // slave may still hold its acknowledge
            scl = 1'h1;
            #HALF;
        end
        sda_pull = 1'h1;
        #HALF;
        scl = 1'h0;
    endtask
    // stop: data rises while the clock is high, then bus released
    task automatic bus_stop();
        #(HALF/4);
        sda_pull = 1'h1;
        #(HALF*3/4);
        scl = 1'h1;
        #HALF;
        sda_pull = 1'h0;
        #HALF;
    endtask
    // one clock: data set while low, sampled mid high
    task automatic bit_cycle(input logic v, output logic seen);
        #(HALF/4);
        sda_pull = ~v;
        #(HALF*3/4);
        scl = 1'h1;
        #(HALF/2);
        seen = sda_line;
        #(HALF/2);
        scl = 1'h0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'h1, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'h1, s);
            b[i] = s;
        end
        bit_cycle(~give_ack, s);
    endtask
endmodule

// *** verilog/tws_slave.sv ***
// Purpose: two-wire slave port writing and reading 8-bit registers
// Assumes: mclk far faster than the serial clock (100 MHz vs 400 kHz)
// Notes: register storage itself lives outside; read data is rd_data
`timescale 1ns/1ns
`include "tws_cfg.svh"
module tws_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // address select pins
    input wire logic [1:0] addr_sel,
    // register side
    output tws_pkg::tws_req_t reg_req,
    output logic reg_wr,
    input wire logic [7:0] rd_data,
    output logic [7:0] ptr
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // three stages; a change counts when the last two agree
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_f;
    logic sda_f;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
        end else begin
            scl_sy <= {scl_sy[1:0], scl_in};
            sda_sy <= {sda_sy[1:0], sda_in};
        end
    end
    // filtered levels hold until stages 2 and 3 agree
    wire scl_agree = (scl_sy[1] == scl_sy[2]);
    wire sda_agree = (sda_sy[1] == sda_sy[2]);
    wire next_scl_f = scl_agree ? scl_sy[2] : scl_f;
    wire next_sda_f = sda_agree ? sda_sy[2] : sda_f;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_f <= 1'h1;
            sda_f <= 1'h1;
        end else begin
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
        end
    end
    // ---------------------------------------------------------------
    // bus events
    // ---------------------------------------------------------------
    // 10 ns sampling gives 250 samples per fast-rate period
    wire scl_rise = next_scl_f & ~scl_f;
    wire scl_fall = ~next_scl_f & scl_f;
    wire start_ev = scl_f & next_scl_f & sda_f & ~next_sda_f;
    wire stop_ev = scl_f & next_scl_f & ~sda_f & next_sda_f;
    // ---------------------------------------------------------------
    // byte engine
    // ---------------------------------------------------------------
    tws_pkg::tws_state_t state;
    tws_pkg::tws_state_t next_state;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic is_read;
    logic ptr_phase;
    logic [7:0] txbyte;
    logic ack_low;
    wire [7:0] next_shreg = {shreg[6:0], sda_f};
    wire addr_hit = (next_shreg[7:1] == {`TWS_ADDR_HI, addr_sel});
    wire last_bit = (bitcnt == `TWS_BIT_LAST);
    // next state on the events that move the engine
    always_comb begin
        next_state = state;
        if (start_ev) begin
            next_state = tws_pkg::ST_ADDR;
        end else if (stop_ev) begin
            next_state = tws_pkg::ST_IDLE;
        end else begin
            case (state)
                tws_pkg::ST_IDLE: begin
                    next_state = tws_pkg::ST_IDLE;
                end
                tws_pkg::ST_ADDR: begin
                    if (scl_rise && last_bit) begin
                        next_state = addr_hit ? tws_pkg::ST_AACK
                                              : tws_pkg::ST_IDLE;
                    end
                end
                tws_pkg::ST_AACK: begin
                    // first fall arms the ack, second fall ends it
                    if (scl_fall && ack_low) begin
                        next_state = is_read ? tws_pkg::ST_TXB
                                             : tws_pkg::ST_RXB;
                    end
                end
                tws_pkg::ST_RXB: begin
                    if (scl_rise && last_bit) begin
                        next_state = tws_pkg::ST_RACK;
                    end
                end
                tws_pkg::ST_RACK: begin
                    if (scl_fall && ack_low) begin
                        next_state = tws_pkg::ST_RXB;
                    end
                end
                tws_pkg::ST_TXB: begin
                    if (scl_fall && last_bit) begin
                        next_state = tws_pkg::ST_TACK;
                    end
                end
                tws_pkg::ST_TACK: begin
                    // master ack reads again; nack releases the line
                    if (scl_rise) begin
                        next_state = sda_f ? tws_pkg::ST_IDLE
                                           : tws_pkg::ST_TXB;
                    end
                end
                default: begin
                    next_state = tws_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // state register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= tws_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end
    // bit counter: counts scl rises in receive, falls in transmit
    wire rx_st = (state == tws_pkg::ST_ADDR) || (state == tws_pkg::ST_RXB);
    wire cnt_step = (rx_st && scl_rise) ||
                    ((state == tws_pkg::ST_TXB) && scl_fall);
    wire cnt_clr = start_ev || (next_state != state);
    wire [2:0] next_bitcnt = cnt_clr ? `TWS_BIT_ZERO
                           : cnt_step ? bitcnt + 3'h1 : bitcnt;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bitcnt <= `TWS_BIT_ZERO;
        end else begin
            bitcnt <= next_bitcnt;
        end
    end
    // receive shift, msb first; latch direction at the address byte
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            shreg <= `TWS_BYTE_RST;
            is_read <= `TWS_DIR_WRITE;
        end else if (rx_st && scl_rise) begin
            shreg <= next_shreg;
            if (state == tws_pkg::ST_ADDR && last_bit) begin
                is_read <= sda_f;
            end
        end
    end
    // ack slot: drive only after scl falls, so data never moves while
    // scl is high and no false start or stop is made by the slave
    wire ack_wait = (state == tws_pkg::ST_AACK) ||
                    (state == tws_pkg::ST_RACK);
    wire ack_arm = ack_wait && scl_fall && !ack_low;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ack_low <= 1'h0;
        end else if (next_state != state) begin
            ack_low <= 1'h0;
        end else if (ack_arm) begin
            ack_low <= 1'h1;
        end
    end
    // first byte of a write transfer is the pointer, later ones data
    wire byte_done = (state == tws_pkg::ST_RXB) && scl_rise && last_bit;
    wire ptr_load = byte_done && ptr_phase;
    wire data_store = byte_done && !ptr_phase;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr_phase <= 1'h1;
        end else if (state == tws_pkg::ST_AACK) begin
            ptr_phase <= 1'h1;
        end else if (byte_done) begin
            ptr_phase <= 1'h0;
        end
    end
    // pointer held until reset or next write transfer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr <= `TWS_PTR_RST;
        end else if (ptr_load) begin
            ptr <= next_shreg;
        end
    end
    // write strobe and request, one cycle per received data byte
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_wr <= 1'h0;
            reg_req <= '0;
        end else begin
            reg_wr <= data_store;
            if (data_store) begin
                reg_req <= '{ptr: ptr, data: next_shreg, wr: 1'h1};
            end else begin
                reg_req.wr <= 1'h0;
            end
        end
    end
    // transmit byte captured from the retained register at address ack end or at the scl rise of a master ack
    wire tx_load = (state == tws_pkg::ST_AACK && scl_fall && ack_low
                    && is_read) ||
                   (state == tws_pkg::ST_TACK && scl_rise && !sda_f);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            txbyte <= `TWS_BYTE_RST;
        end else if (tx_load) begin
            txbyte <= rd_data;
        end else if (state == tws_pkg::ST_TXB && scl_fall) begin
            txbyte <= {txbyte[6:0], 1'h0};
        end
    end
    // ---------------------------------------------------------------
    // data line driver
    // ---------------------------------------------------------------
    // pull low only for acks and zero read bits; changes follow scl low, except the first bit after a master ack, set at scl rise
    wire ack_st = ack_wait && (next_state == state) &&
                  (ack_low || ack_arm);
    wire tx_low = (next_state == tws_pkg::ST_TXB) &&
                  !(tx_load ? rd_data[7] : txbyte[7]);
    wire drive_low = ack_st || tx_low;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sda_out <= 1'h1;
            sda_oe_n <= 1'h1;
        end else begin
            sda_out <= 1'h0;
            sda_oe_n <= !drive_low;
        end
    end
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_wbyte;
        (state == tws_pkg::ST_RXB) && scl_rise && last_bit && !ptr_phase;
    endsequence
    chk_write_strobe: assert property (@(posedge mclk) disable iff (!rstn)
        s_wbyte |=> reg_wr && reg_req.ptr == $past(ptr))
        else $error("write strobe missing");
    chk_ptr_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !ptr_load |=> $stable(ptr))
        else $error("pointer changed without load");
    chk_addr_ack: assert property (@(posedge mclk) disable iff (!rstn)
        (state == tws_pkg::ST_AACK && ack_arm
         && !start_ev && !stop_ev) |=> !sda_oe_n)
        else $error("address not acknowledged");
    chk_miss_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        (state == tws_pkg::ST_IDLE && next_state == tws_pkg::ST_IDLE)
        |=> sda_oe_n)
        else $error("drive while idle");
    chk_start_det: assert property (@(posedge mclk) disable iff (!rstn)
        start_ev |=> state == tws_pkg::ST_ADDR)
        else $error("start missed");
    chk_stop_det: assert property (@(posedge mclk) disable iff (!rstn)
        stop_ev |=> state == tws_pkg::ST_IDLE)
        else $error("stop missed");
    chk_nack_end: assert property (@(posedge mclk) disable iff (!rstn)
        (state == tws_pkg::ST_TACK && scl_rise && sda_f && !stop_ev
         && !start_ev) |=> state == tws_pkg::ST_IDLE ##1 sda_oe_n)
        else $error("nack not released");
    chk_drive_only: assert property (@(posedge mclk) disable iff (!rstn)
        !sda_oe_n |-> !sda_out)
        else $error("drive high seen");
    chk_dir_pick: assert property (@(posedge mclk) disable iff (!rstn)
        (state == tws_pkg::ST_AACK && scl_fall && ack_low && !start_ev
         && !stop_ev)
        |=> state == (is_read ? tws_pkg::ST_TXB : tws_pkg::ST_RXB))
        else $error("direction wrong");
endmodule
